//--- pkg/csf_pkg.sv
// Package: constants and types for the CPU core datapath and status word
package csf_pkg;

    // Widths
    localparam int PC_W        = 23;
    localparam int INSN_W      = 24;
    localparam int DATA_W      = 16;
    localparam int NUM_WREG    = 16;
    localparam int WIDX_W      = 4;
    localparam int DADDR_W     = 16;
    localparam int PAGE_W      = 8;

    // APB register byte offsets
    localparam logic [11:0] OFF_STATUS   = 12'h000;
    localparam logic [11:0] OFF_CORECTL  = 12'h004;
    localparam logic [11:0] OFF_INTCFG1  = 12'h008;
    localparam logic [11:0] OFF_PWPAGE   = 12'h00C;
    localparam logic [11:0] OFF_PC       = 12'h010;
    localparam logic [11:0] OFF_WREG0    = 12'h040;

    // Status word and control register field positions
    localparam int SB_HALF  = 8;
    localparam int SB_IPL_H = 7;
    localparam int SB_IPL_L = 5;
    localparam int SB_RPT   = 4;
    localparam int SB_NEG   = 3;
    localparam int SB_OVF   = 2;
    localparam int SB_ZERO  = 1;
    localparam int SB_CARRY = 0;
    localparam logic [15:0] STATUS_WMASK = 16'h01EF;
    localparam int CC_PLMSB   = 3;
    localparam int CC_PSV     = 2;
    localparam int IC1_NESTING_DISABLE = 15;

    // Reset values
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [22:0] PC_RST     = 23'h000000;

    // Divider: 19 instruction cycles in total, one bit per cycle for 16 of them
    localparam logic [4:0] DIV_CYCLES = 5'h13;
    localparam logic [4:0] DIV_BITS   = 5'h10;

    // Data space layout
    localparam logic [15:0] DMA_RAM_BASE = 16'h0800;
    localparam logic [15:0] DMA_RAM_SIZE = 16'h0800;

    // Operation codes of the execute port
    typedef enum logic [3:0] {
        CSF_OP_NOP, CSF_OP_ADD, CSF_OP_SUB, CSF_OP_AND, CSF_OP_OR, CSF_OP_XOR,
        CSF_OP_MUL, CSF_OP_SHIFT, CSF_OP_DIV, CSF_OP_MOVE, CSF_OP_REPEAT,
        CSF_OP_BRANCH, CSF_OP_MOVD, CSF_OP_TABLE
    } csf_op_e;

    typedef enum logic [1:0] { CSF_ST_RUN, CSF_ST_STALL, CSF_ST_DIV } csf_state_e;

endpackage

//--- design/csf_core.sv
// CPU core datapath: fetch, working registers, ALU, multiplier, divider, shifter, status word
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/1ps

// Summary of operation
// - 23-bit PC fetches 24-bit instruction words
// - single cycle except flow, move-double, table, divide
// - repeat loops free, interruptible any iteration
// - sixteen 16-bit registers, last is stack
// - memory read, register read, write, fetch
// - data space linear 32K words, 64 Kbytes
// - upper half maps program space via page
// - single-cycle 17x17 signed/unsigned/mixed multiplier
// - divide iterative, 19 cycles, interrupt safe
// - shifter moves up to 16 bits once
// - half carry from bit 4 or 8
// - priority field bits 7-5, 7 disables
// - priority msb extends level to 8-15
// - nesting disable makes priority field read-only
// - repeat active reads 1 during loop
// - negative flag follows result sign
// - overflow flag on signed wrap
// - zero flag set by zero result, cleared by nonzero
// - carry flag from result msb
// - bits 15-9 zero, reset clears all
// - subtraction uses carries as borrows
module csf_core
    import csf_pkg::*;
(
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Instruction port
    input  wire logic              insn_valid,
    input  wire logic [3:0]        insn_op,
    input  wire logic              insn_byte,
    input  wire logic              insn_signed_a,
    input  wire logic              insn_signed_b,
    input  wire logic              insn_mem_src,
    input  wire logic [3:0]        insn_ra,
    input  wire logic [3:0]        insn_rb,
    input  wire logic [3:0]        insn_rd,
    input  wire logic [15:0]       insn_imm,
    input  wire logic              insn_wr_mem,
    input  wire logic              insn_flags,
    output logic                   insn_ready,
    // Program and data memory
    output logic      [22:0]       fetch_addr,
    input  wire logic [23:0]       fetch_word,
    output logic      [15:0]       dmem_addr,
    input  wire logic [15:0]       dmem_rdata,
    output logic                   dmem_we,
    output logic      [15:0]       dmem_wdata,
    output logic                   dmem_psv_hit,
    output logic      [23:0]       dmem_psv_addr,
    output logic                   dmem_dma_hit,
    // Interrupt controller
    input  wire logic              irq_take,
    output logic      [3:0]        cpu_priority,
    output logic                   user_irq_disabled
);

    typedef struct packed {
        logic [22:0]             pc;
        logic [15:0][15:0]       wreg;
        logic [15:0]             status;
        logic                    plmsb;
        logic                    psv_en;
        logic                    nesting_disable;
        logic [7:0]              pwpage;
        logic [15:0]             rpt_cnt;
        logic [4:0]              div_cnt;
        logic [31:0]             div_rem;
        logic [15:0]             div_quo;
        logic [15:0]             div_dsr;
        logic [3:0]              div_dst;
        csf_state_e              state;
        logic                    stall_one;
        logic [31:0]             prdata;
        logic                    dmem_we;
        logic [15:0]             dmem_wdata;
        logic [15:0]             dmem_addr;
    } csf_s;

    csf_s q;
    csf_s n;

    logic        apb_wr;
    logic        apb_rd;
    logic        hit;
    logic [15:0] opa;
    logic [15:0] opb;
    logic [16:0] sum;
    logic [8:0]  sum_lo;
    logic [4:0]  sum_nib;
    logic [33:0] prod;
    logic [15:0] res;
    logic        res_c;
    logic        res_h;
    logic        res_v;
    logic        do_flags;
    logic [31:0] shl;
    logic [31:0] shr;
    logic [4:0]  shamt;
    logic [32:0] div_try;
    logic        next_zero;
    logic [15:0] wv;

    // Single-cycle APB: zero wait states
    assign pready  = 1'b1;
    assign apb_wr  = psel && penable && pwrite;
    assign apb_rd  = psel && !penable && !pwrite;
    assign prdata  = q.prdata;
    assign pslverr = psel && penable && !hit;
    assign hit     = (paddr == OFF_STATUS) || (paddr == OFF_CORECTL) || (paddr == OFF_INTCFG1)
                     || (paddr == OFF_PWPAGE) || (paddr == OFF_PC)
                     || (paddr[11:6] == OFF_WREG0[11:6]);

    // Datapath ready unless stalled for multi-cycle operations
    assign insn_ready = (q.state == CSF_ST_RUN);

    // Fetch and data space outputs
    assign fetch_addr        = q.pc;
    assign dmem_addr         = q.dmem_addr;
    assign dmem_we           = q.dmem_we;
    assign dmem_wdata        = q.dmem_wdata;
    assign dmem_psv_hit      = q.psv_en && q.dmem_addr[15];
    assign dmem_psv_addr     = {1'b0, q.pwpage, q.dmem_addr[14:0]};
    assign dmem_dma_hit      = (q.dmem_addr >= DMA_RAM_BASE)
                               && (q.dmem_addr < DMA_RAM_BASE + DMA_RAM_SIZE);
    assign cpu_priority      = {q.plmsb, q.status[SB_IPL_H:SB_IPL_L]};
    assign user_irq_disabled = q.plmsb || (q.status[SB_IPL_H:SB_IPL_L] == 3'h7);

    // Operands: register or memory on port A, register only on port B
    assign opa = insn_mem_src ? dmem_rdata : q.wreg[insn_ra];
    assign opb = q.wreg[insn_rb];

    // Adder with borrow sense on subtraction
    assign sum     = (insn_op == CSF_OP_SUB) ? ({1'b0, opa} + {1'b0, ~opb} + 17'h00001)
                                             : ({1'b0, opa} + {1'b0, opb});
    assign sum_nib = (insn_op == CSF_OP_SUB) ? ({1'b0, opa[3:0]} + {1'b0, ~opb[3:0]} + 5'h01)
                                             : ({1'b0, opa[3:0]} + {1'b0, opb[3:0]});
    assign sum_lo  = (insn_op == CSF_OP_SUB) ? ({1'b0, opa[7:0]} + {1'b0, ~opb[7:0]} + 9'h001)
                                             : ({1'b0, opa[7:0]} + {1'b0, opb[7:0]});

    // 17x17 multiplier: the extra bit carries each operand's sign
    assign prod = $signed({insn_signed_a & opa[15], opa})
                  * $signed({insn_signed_b & opb[15], opb});

    // Shifter: signed amount, positive right, negative left
    assign shamt = insn_imm[15] ? 5'(-insn_imm[4:0]) : insn_imm[4:0];
    assign shl   = {16'h0000, opa} << shamt;
    assign shr   = insn_signed_a ? 32'($signed({{16{opa[15]}}, opa}) >>> shamt)
                                 : ({16'h0000, opa} >> shamt);

    // Restoring divider step
    assign div_try = {q.div_rem, 1'b0} - {1'b0, q.div_dsr, 16'h0000};

    // ALU result and raw flags
    always_comb begin
        res      = 16'h0000;
        res_c    = 1'b0;
        res_h    = 1'b0;
        res_v    = 1'b0;
        do_flags = insn_flags;
        case (insn_op)
            CSF_OP_ADD, CSF_OP_SUB: begin
                res   = sum[15:0];
                res_c = insn_byte ? sum_lo[8] : sum[16];
                res_h = insn_byte ? sum_nib[4] : sum_lo[8];
                res_v = insn_byte ? ((opa[7] ^ sum[7]) & ((insn_op == CSF_OP_SUB) ^ opa[7] ^ ~opb[7]))
                                  : ((opa[15] ^ sum[15]) & ((insn_op == CSF_OP_SUB) ^ opa[15] ^ ~opb[15]));
            end
            CSF_OP_AND:   res = opa & opb;
            CSF_OP_OR:    res = opa | opb;
            CSF_OP_XOR:   res = opa ^ opb;
            CSF_OP_MOVE:  res = opa;
            CSF_OP_MUL: begin
                res      = prod[15:0];
                do_flags = 1'b0;
            end
            CSF_OP_SHIFT: begin
                res   = insn_imm[15] ? shl[15:0] : shr[15:0];
                res_c = insn_imm[15] ? shl[16] : 1'b0;
            end
            default: begin
                res      = 16'h0000;
                do_flags = 1'b0;
            end
        endcase
        if (insn_byte) begin
            res[15:8] = opa[15:8];
        end
    end

    // Next-state logic for the whole core
    always_comb begin
        n           = q;
        n.dmem_we   = 1'b0;
        n.prdata    = 32'h00000000;
        next_zero   = insn_byte ? (res[7:0] == 8'h00) : (res == 16'h0000);
        wv          = 16'h0000;
        case (q.state)
            CSF_ST_RUN: begin
                if (insn_valid) begin
                    n.pc = 23'(q.pc + 23'h000002);
                    if (insn_op == CSF_OP_MUL) begin
                        n.wreg[insn_rd]                = prod[15:0];
                        n.wreg[4'(insn_rd + 4'h1)]     = prod[31:16];
                    end else if (insn_op == CSF_OP_DIV) begin
                        n.div_rem = insn_byte ? {16'h0000, opa} : {q.wreg[4'(insn_ra + 4'h1)], opa};
                        n.div_dsr = opb;
                        n.div_quo = 16'h0000;
                        n.div_cnt = DIV_CYCLES;
                        n.state   = CSF_ST_DIV;
                    end else if (insn_op == CSF_OP_REPEAT) begin
                        n.rpt_cnt = insn_imm;
                    end else if (insn_op == CSF_OP_BRANCH) begin
                        n.pc        = {insn_imm, 7'h00};
                        n.state     = CSF_ST_STALL;
                    end else if (insn_op == CSF_OP_MOVD || insn_op == CSF_OP_TABLE) begin
                        n.wreg[insn_rd]            = opa;
                        n.wreg[4'(insn_rd + 4'h1)] = q.wreg[4'(insn_ra + 4'h1)];
                        n.state                   = CSF_ST_STALL;
                    end else if (insn_op != CSF_OP_NOP) begin
                        if (insn_wr_mem) begin
                            n.dmem_we    = 1'b1;
                            n.dmem_wdata = res;
                        end else begin
                            n.wreg[insn_rd] = res;
                        end
                    end
                    n.dmem_addr = q.wreg[insn_rd];
                    if (do_flags) begin
                        n.status[SB_NEG]   = insn_byte ? res[7] : res[15];
                        n.status[SB_OVF]   = res_v;
                        n.status[SB_CARRY] = res_c;
                        n.status[SB_HALF]  = res_h;
                        n.status[SB_ZERO]  = next_zero;
                    end
                    // Repeated instruction reissued by the sequencer; pc held until count expires
                    if (q.rpt_cnt != 16'h0000 && insn_op != CSF_OP_REPEAT) begin
                        n.rpt_cnt = 16'(q.rpt_cnt - 16'h0001);
                        n.pc      = q.pc;
                    end
                end
            end
            CSF_ST_DIV: begin
                // Partial state lives in registers, so an interrupt only pauses it
                if (!irq_take) begin
                    n.div_cnt = 5'(q.div_cnt - 5'h01);
                    if (q.div_cnt <= DIV_BITS && q.div_cnt != 5'h00) begin
                        if (!div_try[32]) begin
                            n.div_rem = div_try[31:0];
                        end else begin
                            n.div_rem = {q.div_rem[30:0], 1'b0};
                        end
                        n.div_quo = {q.div_quo[14:0], !div_try[32]};
                    end
                    if (q.div_cnt == 5'h01) begin
                        n.wreg[0] = n.div_quo;
                        n.wreg[1] = n.div_rem[31:16];
                        n.state   = CSF_ST_RUN;
                    end
                end
            end
            CSF_ST_STALL: begin
                n.state = CSF_ST_RUN;
            end
            default: begin
                n.state = CSF_ST_RUN;
            end
        endcase

        // Software writes land after the instruction's own update
        if (apb_wr) begin
            wv = pwdata[15:0];
            if (paddr == OFF_STATUS) begin
                n.status[SB_HALF]           = wv[SB_HALF];
                n.status[3:0]               = wv[3:0];
                if (!q.nesting_disable) begin
                    n.status[SB_IPL_H:SB_IPL_L] = wv[SB_IPL_H:SB_IPL_L];
                end
            end else if (paddr == OFF_CORECTL) begin
                n.psv_en = wv[CC_PSV];
                if (!wv[CC_PLMSB]) begin
                    n.plmsb = 1'b0;
                end
            end else if (paddr == OFF_INTCFG1) begin
                n.nesting_disable = wv[IC1_NESTING_DISABLE];
            end else if (paddr == OFF_PWPAGE) begin
                n.pwpage = wv[7:0];
            end else if (paddr == OFF_PC) begin
                n.pc = {pwdata[22:1], 1'b0};
            end else if (paddr[11:6] == OFF_WREG0[11:6]) begin
                n.wreg[paddr[5:2]] = wv;
            end
        end
        n.status = n.status & STATUS_WMASK | (16'(n.rpt_cnt != 16'h0000) << SB_RPT);

        // Read data captured in the setup phase
        if (apb_rd) begin
            if (paddr == OFF_STATUS) begin
                n.prdata = {16'h0000, q.status & 16'h01FF};
            end else if (paddr == OFF_CORECTL) begin
                n.prdata = {28'h0000000, q.plmsb, q.psv_en, 2'h0};
            end else if (paddr == OFF_INTCFG1) begin
                n.prdata = {16'h0000, q.nesting_disable, 15'h0000};
            end else if (paddr == OFF_PWPAGE) begin
                n.prdata = {24'h000000, q.pwpage};
            end else if (paddr == OFF_PC) begin
                n.prdata = {9'h000, q.pc};
            end else if (paddr[11:6] == OFF_WREG0[11:6]) begin
                n.prdata = {16'h0000, q.wreg[paddr[5:2]]};
            end
        end
    end

    // State register; reset clears the status word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q        <= '0;
            q.pc     <= PC_RST;
            q.status <= STATUS_RST;
            q.state  <= CSF_ST_RUN;
        end else begin
            q <= n;
        end
    end

endmodule

//--- dv/csf_core_assertions.sv
// Checker: timing and status relations at the core ports
`timescale 1ns/1ps
module csf_core_assertions
    import csf_pkg::*;
(
    // Clock, reset and APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Core side
    input wire logic        insn_valid,
    input wire logic [3:0]  insn_op,
    input wire logic        insn_ready,
    input wire logic [15:0] dmem_addr,
    input wire logic        dmem_psv_hit,
    input wire logic [23:0] dmem_psv_addr,
    input wire logic        dmem_dma_hit,
    input wire logic        irq_take,
    input wire logic [3:0]  cpu_priority,
    input wire logic        user_irq_disabled
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [4:0] lo_cnt;
    logic       div_run;
    logic       irq_seen;
    logic       take;
    logic       rd_st;
    assign take  = insn_valid && insn_ready;
    assign rd_st = psel && penable && !pwrite && paddr == OFF_STATUS;
    // Stall length counter; irq cycles are noted because they stretch a divide
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lo_cnt   <= 5'h00;
            div_run  <= 1'b0;
            irq_seen <= 1'b0;
        end else begin
            lo_cnt   <= insn_ready ? 5'h00 : lo_cnt + 5'h01;
            div_run  <= (take && insn_op == CSF_OP_DIV) || (div_run && !insn_ready);
            irq_seen <= !insn_ready && (irq_seen || irq_take);
        end
    end
    a_apb_zero_wait: assert property (psel && !penable |=> pready)
        else $error("pready low in access phase");
    a_status_upper: assert property (rd_st |-> prdata[15:9] == 7'h00 && prdata[7:5] == cpu_priority[2:0])
        else $error("status read bad upper or priority bits");
    a_status_mapped: assert property (rd_st |-> !pslverr)
        else $error("status read refused");
    a_irq_disable: assert property (user_irq_disabled == (cpu_priority[3] || cpu_priority[2:0] == 3'h7))
        else $error("user irq disable mismatch");
    a_div_stall: assert property (take && insn_op == CSF_OP_DIV |=> !insn_ready [*8])
        else $error("divide released too early");
    a_div_length: assert property (insn_ready && div_run && !irq_seen |-> lo_cnt == 5'h13)
        else $error("divide length wrong");
    a_flow_stall: assert property (take && insn_op inside {CSF_OP_BRANCH, CSF_OP_MOVD, CSF_OP_TABLE}
        |=> !insn_ready ##1 insn_ready)
        else $error("branch stall wrong");
    a_alu_single: assert property (take && insn_op inside {CSF_OP_ADD, CSF_OP_MUL, CSF_OP_SHIFT} |=> insn_ready)
        else $error("single cycle op stalled");
    a_psv_map: assert property (dmem_psv_hit |-> dmem_addr[15] && dmem_psv_addr[14:0] == dmem_addr[14:0])
        else $error("program window address wrong");
    a_dma_window: assert property (dmem_dma_hit == (dmem_addr[15:11] == 5'h01))
        else $error("dma window decode wrong");
endmodule
bind csf_core csf_core_assertions csf_core_assertions_inst (.*);

//--- dv/csf_mem_model.sv
// Partner model: program memory, data memory and interrupt request source
`timescale 1ns/1ps
module csf_mem_model
    import csf_pkg::*;
(
    // Clock and request from the bench
    input wire logic        pclk,
    input wire logic        irq_req,
    // Memory and interrupt ports
    input wire logic [22:0] fetch_addr,
    output logic     [23:0] fetch_word,
    input wire logic [15:0] dmem_addr,
    input wire logic        dmem_we,
    input wire logic [15:0] dmem_wdata,
    output logic     [15:0] dmem_rdata,
    output logic            irq_take
);
    logic [15:0] mem [0:255];
    logic [1:0]  irq_left = 2'h0;
    // Word follows the address so a stale fetch is visible
    assign fetch_word = {1'b0, fetch_addr};
    // Read answers in the same cycle to allow read and write per instruction
    assign dmem_rdata = mem[dmem_addr[8:1]];
    // Pause request stands while the countdown runs
    assign irq_take   = (irq_left != 2'h0);
    // Writes land at the edge; one request holds irq_take for three cycles
    always @(posedge pclk) begin
        if (dmem_we)
            mem[dmem_addr[8:1]] <= dmem_wdata;
        if (irq_req)
            irq_left <= 2'h3;
        else if (irq_left != 2'h0)
            irq_left <= irq_left - 2'h1;
    end
endmodule

//--- dv/cpu_core_status_flags_tb.sv
// Testbench: register, flag, multiply, divide, repeat and priority scenarios
`timescale 1ns/1ps
module cpu_core_status_flags_tb import csf_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq_req, irq_take, last_err;
    logic insn_valid, insn_byte, insn_signed_a, insn_signed_b, insn_mem_src, insn_wr_mem, insn_flags;
    logic insn_ready, dmem_we, dmem_psv_hit, dmem_dma_hit, user_irq_disabled;
    logic [3:0]  pstrb, insn_op, insn_ra, insn_rb, insn_rd, cpu_priority;
    logic [11:0] paddr;
    logic [15:0] insn_imm, dmem_addr, dmem_rdata, dmem_wdata;
    logic [22:0] fetch_addr, pc_keep;
    logic [23:0] fetch_word, dmem_psv_addr;
    logic [31:0] pwdata, prdata, q;
    int          fails, samples_checked;
    csf_core      csf_core_inst (.*);
    csf_mem_model csf_mem_model_inst (.*);
    // 50 MHz clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic logic [11:0] wa(input int i);
        return OFF_WREG0 + 12'(4 * i);
    endfunction
    // One APB transfer; an idle edge follows so drivers never double up
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q        = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    // m = {byte, signed_a, signed_b, flags}
    task automatic op(input logic [3:0] o, ra, rb, rd, input logic [15:0] imm, input logic [3:0] m);
        insn_valid <= 1'b1;
        insn_op    <= o;
        insn_ra    <= ra;
        insn_rb    <= rb;
        insn_rd    <= rd;
        insn_imm   <= imm;
        {insn_byte, insn_signed_a, insn_signed_b, insn_flags} <= m;
        @(posedge pclk);
        while (insn_ready !== 1'b1)
            @(posedge pclk);
        insn_valid <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic t_reset();
        rdchk(OFF_STATUS, 32'h0);
        chk({28'h0, cpu_priority}, 32'h0);
        rdchk(12'hFF0, 32'h0);
        chk({31'h0, last_err}, 32'h1);
    endtask
    task automatic t_add();
        wr(wa(1), 32'h7FFF);
        wr(wa(2), 32'h0001);
        op(CSF_OP_ADD, 4'h1, 4'h2, 4'h3, 16'h0, 4'h1);
        rdchk(wa(3), 32'h8000);
        rdchk(OFF_STATUS, 32'h010C);
        wr(wa(1), 32'hFFFF);
        op(CSF_OP_ADD, 4'h1, 4'h2, 4'h3, 16'h0, 4'h1);
        rdchk(OFF_STATUS, 32'h0103);
        op(CSF_OP_ADD, 4'h2, 4'h2, 4'h3, 16'h0, 4'h0);
        rdchk(wa(3), 32'h0002);
        rdchk(OFF_STATUS, 32'h0103);
        wr(wa(1), 32'h000F);
        op(CSF_OP_ADD, 4'h1, 4'h2, 4'h3, 16'h0, 4'h9);
        rdchk(OFF_STATUS, 32'h0100);
        wr(wa(1), 32'h0000);
        op(CSF_OP_SUB, 4'h1, 4'h2, 4'h3, 16'h0, 4'h1);
        rdchk(wa(3), 32'hFFFF);
        apb(1'b0, OFF_STATUS, 32'h0);
        chk(q & 32'h0000010F, 32'h00000008);
    endtask
    task automatic t_mul();
        logic [31:0] exp [3];
        exp = '{32'hFFFE0001, 32'h00000001, 32'hFFFF0001};
        wr(wa(1), 32'hFFFF);
        wr(wa(2), 32'hFFFF);
        for (int i = 0; i < 3; i++) begin
            op(CSF_OP_MUL, 4'h1, 4'h2, 4'h4, 16'h0, {1'b0, i == 1, i != 0, 1'b0});
            rdchk(wa(4), {16'h0, exp[i][15:0]});
            rdchk(wa(5), {16'h0, exp[i][31:16]});
        end
    endtask
    // Divide, optionally with an interrupt raised in mid-run
    task automatic t_div(input logic irq, input int n_exp);
        int n;
        wr(wa(8), 32'd100);
        wr(wa(9), 32'd7);
        op(CSF_OP_DIV, 4'h8, 4'h9, 4'h0, 16'h0, 4'h8);
        irq_req <= irq;
        n = 0;
        while (insn_ready !== 1'b1 && n < 40) begin
            n++;
            @(posedge pclk);
            irq_req <= 1'b0;
        end
        chk(32'(n), 32'(n_exp));
        rdchk(wa(0), 32'd14);
        rdchk(wa(1), 32'd2);
    endtask
    task automatic t_shift_repeat();
        wr(wa(6), 32'h0123);
        op(CSF_OP_SHIFT, 4'h6, 4'h0, 4'h7, 16'hFFFC, 4'h0);
        rdchk(wa(7), 32'h1230);
        op(CSF_OP_SHIFT, 4'h6, 4'h0, 4'h7, 16'h0010, 4'h0);
        rdchk(wa(7), 32'h0);
        op(CSF_OP_REPEAT, 4'h0, 4'h0, 4'h0, 16'h0002, 4'h0);
        pc_keep = fetch_addr;
        wr(OFF_STATUS, 32'h0);
        rdchk(OFF_STATUS, 32'h0010);
        op(CSF_OP_NOP, 4'h0, 4'h0, 4'h0, 16'h0, 4'h0);
        op(CSF_OP_NOP, 4'h0, 4'h0, 4'h0, 16'h0, 4'h0);
        chk({9'h0, fetch_addr}, {9'h0, pc_keep});
        rdchk(OFF_STATUS, 32'h0);
    endtask
    task automatic t_psv_branch();
        op(CSF_OP_BRANCH, 4'h0, 4'h0, 4'h0, 16'h0040, 4'h0);
        rdchk(OFF_PC, 32'h2000);
        wr(OFF_CORECTL, 32'h4);
        wr(OFF_PWPAGE, 32'h5A);
        wr(wa(10), 32'h8010);
        op(CSF_OP_MOVE, 4'hA, 4'h0, 4'hA, 16'h0, 4'h0);
        chk({31'h0, dmem_psv_hit}, 32'h1);
        chk({8'h0, dmem_psv_addr}, {8'h0, 1'b0, 8'h5A, 15'h0010});
        wr(wa(11), 32'h0010);
        insn_wr_mem <= 1'b1;
        op(CSF_OP_ADD, 4'hB, 4'hB, 4'hB, 16'h0, 4'h0);
        chk({16'h0, dmem_wdata}, 32'h0020);
        {insn_wr_mem, insn_mem_src} <= 2'b01;
        op(CSF_OP_MOVE, 4'h0, 4'h0, 4'hC, 16'h0, 4'h0);
        insn_mem_src <= 1'b0;
        rdchk(wa(12), 32'h0020);
        op(CSF_OP_MOVD, 4'hB, 4'h0, 4'hD, 16'h0, 4'h0);
        rdchk(wa(13), 32'h0010);
        rdchk(wa(14), 32'h0020);
        op(CSF_OP_TABLE, 4'hD, 4'h0, 4'h1, 16'h0, 4'h0);
        rdchk(wa(2), 32'h0020);
    endtask
    task automatic t_prio();
        wr(OFF_STATUS, 32'h00E0);
        chk({27'h0, user_irq_disabled, cpu_priority}, 32'h17);
        wr(OFF_STATUS, 32'h0060);
        chk({27'h0, user_irq_disabled, cpu_priority}, 32'h03);
        wr(OFF_INTCFG1, 32'h8000);
        wr(OFF_STATUS, 32'h00E0);
        rdchk(OFF_STATUS, 32'h0060);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Watchdog: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        fails++;
        close_out();
    end
    // Main sequence
    initial begin
        fails = 0;
        samples_checked = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, insn_valid, insn_byte, insn_signed_a, insn_signed_b} = '0;
        {insn_mem_src, insn_wr_mem, insn_flags, irq_req} = '0;
        {paddr, pwdata, insn_imm, insn_op, insn_ra, insn_rb, insn_rd} = '0;
        pstrb = 4'hF;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_add();
        t_mul();
        t_div(1'b0, 19);
        t_div(1'b1, 22);
        t_shift_repeat();
        t_psv_branch();
        t_prio();
        close_out();
    end
endmodule
